// ===== hw/p6g_pkg.sv
// Constants shared by the eight-bit port with peripheral pin sharing
`default_nettype none
package p6g_pkg;
    // ==========================================================
    // Widths and types
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    typedef logic [DATA_W-1:0] p6g_byte_t;
    typedef logic [ADDR_W-1:0] p6g_addr_t;
    // ==========================================================
    // Register offsets
    localparam p6g_addr_t OFF_LATCH = 8'h00;
    localparam p6g_addr_t OFF_DIR = 8'h01;
    localparam p6g_addr_t OFF_PULLUP = 8'h02;
    localparam p6g_addr_t OFF_STBY = 8'h03;
    localparam p6g_addr_t OFF_PINS = 8'h04;
    // ==========================================================
    // Reset values
    localparam p6g_byte_t RST_LATCH = 8'h00;
    localparam p6g_byte_t RST_DIR = 8'h00;
    localparam p6g_byte_t RST_PULLUP = 8'h00;
    localparam p6g_byte_t RST_STBY = 8'h00;
    localparam p6g_byte_t RD_ZERO = 8'h00;
    // ==========================================================
    // Standby configuration field positions
    localparam int STBY_PIN_STATE_BIT = 0;
    localparam int STBY_EIC_P5_BIT = 1;
    localparam int STBY_EIC_P7_BIT = 2;
    localparam int STBY_IRQ_PIN_SELECT_CTRL_P5_BIT = 3;
    localparam int STBY_IRQ_PIN_SELECT_CTRL_P7_BIT = 4;
    localparam p6g_byte_t STBY_MASK = 8'h1F;
    // ==========================================================
    // Pin positions of the shared functions
    localparam int PIN_PG_A = 0;
    localparam int PIN_PG_B = 1;
    localparam int PIN_CT_A = 2;
    localparam int PIN_CT_B = 3;
    localparam int PIN_CT_CLK = 4;
    localparam int PIN_SER_CLK = 5;
    localparam int PIN_SER_OUT = 6;
    localparam int PIN_SER_IN = 7;
endpackage : p6g_pkg
`default_nettype wire

// ===== hw/p6g_sync.sv
// Two-stage synchroniser for a vector of pin levels
`default_nettype none
module p6g_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    // ==========================================================
    // Stages
    logic [WIDTH-1:0] meta_q; // First stage, read only by the second

    // Both stages reset low so the input path starts quiet
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            meta_q <= '0;
            syncOut <= '0;
        end
        else
        begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : p6g_sync
`default_nettype wire

// ===== hw/p6g_pin_cell.sv
// Output driver state of one port pin: level, enable and pull-up
`default_nettype none
module p6g_pin_cell (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Port configuration
    input wire logic dirOut,
    input wire logic latchBit,
    input wire logic pullCfg,
    // Shared function drive
    input wire logic perOe,
    input wire logic perOut,
    // Standby controls
    input wire logic forceHiz,
    input wire logic holdState,
    // Pad side
    output logic padOut,
    output logic padOe,
    output logic padPullUp
);
    // ==========================================================
    // Next-state decode
    wire logic oeD; // Pin driven next cycle
    wire logic outD; // Level driven next cycle
    wire logic pullD; // Pull-up next cycle

    // Peripheral wins over the latch; forced high impedance wins over both
    assign oeD = !forceHiz && (perOe || dirOut);
    assign outD = perOe ? perOut : latchBit;
    // Pull-up dropped while the pin is being pulled low by the driver
    assign pullD = pullCfg && !(oeD && !outD);

    // Frozen during held standby so the outside world sees no glitch
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            padOut <= 1'b0;
            padOe <= 1'b0;
            padPullUp <= 1'b0;
        end
        else if (!holdState)
        begin
            padOut <= outD;
            padOe <= oeD;
            padPullUp <= pullD;
        end
    end
endmodule : p6g_pin_cell
`default_nettype wire

// ===== hw/p6g_port.sv
// Eight-bit general-purpose port with shared peripheral pins
// Behaviour
// - Direction bit one makes the pin output
// - Direction bit zero makes pin input, released
// - Output pin drives its latch bit level
// - Latch write always stored, shown on outputs
// - Normal read of output pin returns latch
// - Input pin read gives pin; RMW latch
// - Peripheral output enable takes over the pin
// - Peripheral-driven pin reads pin; RMW latch
// - Input read gives pin despite peripheral use
// - Reset clears every direction bit to input
// - Pin-state one in standby: all pins float
// - Floated pins gate input path to low
// - Pins 5,7 ungated when interrupt enabled twice
// - Pin-state zero in standby holds pin states
// - Pull-up bit one connects the pull-up
// - Pull-up disconnected while pin driven low
// - Register bit n controls pin n
// - Fixed peripheral signal per pin
`default_nettype none
module p6g_port
    import p6g_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire p6g_pkg::p6g_addr_t regAddr,
    input wire p6g_pkg::p6g_byte_t regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic regRdRmw,
    output p6g_pkg::p6g_byte_t regRdData,
    // Standby state from the standby controller
    input wire logic stopWatchMode,
    // Shared function outputs toward the pins
    input wire logic pulseGenOutA,
    input wire logic pulseGenOutAOe,
    input wire logic pulseGenOutB,
    input wire logic pulseGenOutBOe,
    input wire logic compTimerOutA,
    input wire logic compTimerOutAOe,
    input wire logic compTimerOutB,
    input wire logic compTimerOutBOe,
    input wire logic serialClockOut,
    input wire logic serialClockOutOe,
    input wire logic serialDataOut,
    input wire logic serialDataOutOe,
    // Shared function inputs from the pins
    output logic compTimerExtClock,
    output logic serialClockIn,
    output logic serialDataIn,
    // Pads
    input wire p6g_pkg::p6g_byte_t padIn,
    output p6g_pkg::p6g_byte_t padOut,
    output p6g_pkg::p6g_byte_t padOe,
    output p6g_pkg::p6g_byte_t padPullUp
);
    import p6g_pkg::*;

    // ==========================================================
    // Registers
    p6g_byte_t latch_q; // Output latch
    p6g_byte_t dir_q; // Direction, one is output
    p6g_byte_t pull_q; // Pull-up enables
    p6g_byte_t stby_q; // Standby pin handling options
    p6g_byte_t pinSync; // Synchronised pad levels
    p6g_byte_t perOeVec; // Peripheral enables by pin
    p6g_byte_t perOutVec; // Peripheral levels by pin
    p6g_byte_t gateMask; // Inputs forced low in standby
    p6g_byte_t pinSeen; // Input path after gating
    p6g_byte_t latchSel; // Bits that read back the latch
    p6g_byte_t rdMux; // Read data before the output flop

    // ==========================================================
    // Decode
    wire logic wrLatch;
    wire logic wrDir;
    wire logic wrPull;
    wire logic wrStby;
    wire logic splSet; // Pin-state option
    wire logic forceHiz; // Standby with pins floated
    wire logic holdState; // Standby with pins frozen
    wire logic p5Exempt; // Pin 5 keeps its input in standby
    wire logic p7Exempt; // Pin 7 keeps its input in standby

    assign wrLatch = regWrEn && (regAddr == OFF_LATCH);
    assign wrDir = regWrEn && (regAddr == OFF_DIR);
    assign wrPull = regWrEn && (regAddr == OFF_PULLUP);
    assign wrStby = regWrEn && (regAddr == OFF_STBY);
    assign splSet = stby_q[STBY_PIN_STATE_BIT];
    assign forceHiz = stopWatchMode && splSet;
    assign holdState = stopWatchMode && !splSet;
    // Both interrupt enables are needed before the gate is bypassed
    assign p5Exempt = stby_q[STBY_EIC_P5_BIT] && stby_q[STBY_IRQ_PIN_SELECT_CTRL_P5_BIT];
    assign p7Exempt = stby_q[STBY_EIC_P7_BIT] && stby_q[STBY_IRQ_PIN_SELECT_CTRL_P7_BIT];

    // ==========================================================
    // Pin sharing map
    // Input-only pins 4 and 7 never get a peripheral driver
    assign perOeVec = {1'b0, serialDataOutOe, serialClockOutOe, 1'b0,
                       compTimerOutBOe, compTimerOutAOe,
                       pulseGenOutBOe, pulseGenOutAOe};
    assign perOutVec = {1'b0, serialDataOut, serialClockOut, 1'b0,
                        compTimerOutB, compTimerOutA,
                        pulseGenOutB, pulseGenOutA};

    // ==========================================================
    // Input path
    // Pads cross into the clock domain before anything reads them
    // Two flops cost two cycles of read latency but keep metastability out
    p6g_sync #(
        .WIDTH(DATA_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .asyncIn(padIn),
        .syncOut(pinSync)
    );

    // Floating pins would leak, so their input is tied low in standby
    assign gateMask = forceHiz ?
        ~{p7Exempt, 1'b0, p5Exempt, 5'b00000} : 8'h00;
    assign pinSeen = pinSync & ~gateMask;

    // Peripheral inputs registered so the outputs come from flops
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            compTimerExtClock <= 1'b0;
            serialClockIn <= 1'b0;
            serialDataIn <= 1'b0;
        end
        else
        begin
            compTimerExtClock <= pinSeen[PIN_CT_CLK];
            serialClockIn <= pinSeen[PIN_SER_CLK];
            serialDataIn <= pinSeen[PIN_SER_IN];
        end
    end

    // ==========================================================
    // Register writes
    // Latch takes every write regardless of direction
    // Writes to unmapped offsets match no decode and are dropped
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            latch_q <= RST_LATCH;
            dir_q <= RST_DIR;
            pull_q <= RST_PULLUP;
            stby_q <= RST_STBY;
        end
        else
        begin
            if (wrLatch)
            begin
                latch_q <= regWrData;
            end
            if (wrDir)
            begin
                dir_q <= regWrData;
            end
            if (wrPull)
            begin
                pull_q <= regWrData;
            end
            if (wrStby)
            begin
                stby_q <= regWrData & STBY_MASK;
            end
        end
    end

    // ==========================================================
    // Read path
    // Latch is returned for RMW reads and for pins the port itself drives
    assign latchSel = regRdRmw ? 8'hFF : (dir_q & ~perOeVec);
    always_comb
    begin
        unique case (regAddr)
            OFF_LATCH: rdMux = (latch_q & latchSel) | (pinSeen & ~latchSel);
            OFF_DIR: rdMux = dir_q;
            OFF_PULLUP: rdMux = pull_q;
            OFF_STBY: rdMux = stby_q;
            OFF_PINS: rdMux = pinSeen;
            default: rdMux = RD_ZERO; // Unmapped reads give zero
        endcase
    end

    // Read data stands only in the cycle after the strobe
    // Clearing between reads means a stale word never passes for an answer
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            regRdData <= RD_ZERO;
        end
        else
        begin
            regRdData <= regRdEn ? rdMux : RD_ZERO;
        end
    end

    // ==========================================================
    // Pin drivers
    for (genvar i = 0; i < DATA_W; i++)
    begin : g_pin
        p6g_pin_cell u_cell (
            .sys_clk(sys_clk),
            .rst(rst),
            .dirOut(dir_q[i]),
            .latchBit(latch_q[i]),
            .pullCfg(pull_q[i]),
            .perOe(perOeVec[i]),
            .perOut(perOutVec[i]),
            .forceHiz(forceHiz),
            .holdState(holdState),
            .padOut(padOut[i]),
            .padOe(padOe[i]),
            .padPullUp(padPullUp[i])
        );
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Reset leaves every pin an input; checked while reset is still high
    dir_reset_a: assert property (disable iff (1'b0) rst |=> (dir_q == 8'h00))
        else $error("direction not cleared by reset");

    // Enable follows direction and peripheral enables when active
    pin_enable_a: assert property (
        !stopWatchMode |=> (padOe == $past(dir_q | perOeVec)))
        else $error("pad enable does not follow direction");

    // Pins with neither direction nor peripheral enable stay released
    in_release_a: assert property (
        !stopWatchMode |=> ((padOe & ~$past(dir_q | perOeVec)) == 8'h00))
        else $error("input pin still driven");

    // Port-driven pins show the latch
    latch_drive_a: assert property (
        !stopWatchMode |=> (((padOut ^ $past(latch_q)) & $past(dir_q & ~perOeVec)) == 8'h00))
        else $error("output pin level differs from latch");

    // Peripheral-driven pins show the peripheral level
    periph_drive_a: assert property (
        !stopWatchMode |=> (((padOut ^ $past(perOutVec)) & $past(perOeVec)) == 8'h00))
        else $error("peripheral level not on pin");

    // Latch write stored whatever the direction
    latch_write_a: assert property (wrLatch |=> (latch_q == $past(regWrData)))
        else $error("latch write lost");

    // Read-modify-write reads return the latch
    rmw_read_a: assert property (
        (regRdEn && regRdRmw && regAddr == OFF_LATCH) |=> (regRdData == $past(latch_q)))
        else $error("rmw read did not return latch");

    // Normal reads of port-driven pins return the latch
    out_read_a: assert property (
        (regRdEn && !regRdRmw && regAddr == OFF_LATCH) |=>
        (((regRdData ^ $past(latch_q)) & $past(dir_q & ~perOeVec)) == 8'h00))
        else $error("output pin read did not return latch");

    // Normal reads of non-driven pins return the gated pin level
    pin_read_a: assert property (
        (regRdEn && !regRdRmw && regAddr == OFF_LATCH) |=>
        ((regRdData & ~$past(latchSel)) == ($past(pinSeen) & ~$past(latchSel))))
        else $error("normal read did not return pin level");

    // Direction register reads back bit for bit
    dir_read_a: assert property (
        (regRdEn && regAddr == OFF_DIR) |=> (regRdData == $past(dir_q)))
        else $error("direction read back wrong");

    // A stale read word must never look like a fresh answer
    rd_idle_a: assert property (!regRdEn |=> (regRdData == 8'h00))
        else $error("read data held beyond one cycle");

    // Pad levels reach the read path through exactly two flops
    pin_sync_a: assert property (
        (!$past(rst) && !$past(rst, 2)) |-> (pinSync == $past(padIn, 2)))
        else $error("pad level not synchronised in two stages");

    // Peripheral inputs are the gated pin levels one flop later
    periph_in_a: assert property (
        {serialDataIn, serialClockIn, compTimerExtClock} ==
        $past({pinSeen[PIN_SER_IN], pinSeen[PIN_SER_CLK], pinSeen[PIN_CT_CLK]}))
        else $error("peripheral input not taken from its pin");

    // Floated standby releases every pin from its second cycle on
    hiz_float_a: assert property (forceHiz[*2] |-> (padOe == 8'h00))
        else $error("pin driven in floating standby");

    // Gated inputs read low
    gate_low_a: assert property (
        forceHiz |-> ((pinSeen & 8'h5F) == 8'h00) && (p5Exempt || !pinSeen[PIN_SER_CLK])
        && (p7Exempt || !pinSeen[PIN_SER_IN]))
        else $error("standby input not gated low");

    // Exempt interrupt pins keep their level so a wake-up edge is still seen
    irq_exempt_a: assert property (
        forceHiz |-> ((pinSeen[PIN_SER_CLK] == (p5Exempt && pinSync[PIN_SER_CLK]))
        && (pinSeen[PIN_SER_IN] == (p7Exempt && pinSync[PIN_SER_IN]))))
        else $error("interrupt pin gating wrong in standby");

    // Held standby freezes the pads
    hold_state_a: assert property (
        holdState |=> $stable(padOut) && $stable(padOe) && $stable(padPullUp))
        else $error("pads changed in held standby");

    // Configured pull-up is connected unless the pin is driven low
    pull_conn_a: assert property (
        !stopWatchMode |=> (((padPullUp ^ $past(pull_q)) & ~(padOe & ~padOut)) == 8'h00))
        else $error("configured pull-up not connected");

    // Pull-up never fights a low drive
    pull_low_a: assert property ((padPullUp & padOe & ~padOut) == 8'h00)
        else $error("pull-up active on low-driven pin");

    // Unmapped reads answer zero
    unmapped_a: assert property ((regRdEn && regAddr > OFF_PINS) |=> (regRdData == 8'h00))
        else $error("unmapped read not zero");

    // Main scenarios
    rmw_c: cover property (regRdEn && regRdRmw && (dir_q != 8'h00));
    hiz_c: cover property (forceHiz && p5Exempt ##1 forceHiz);
    periph_c: cover property (!stopWatchMode && (perOeVec != 8'h00) ##1 padOe[PIN_SER_CLK]);
    hold_c: cover property (holdState[*3]);
    pull_c: cover property ((padPullUp & ~padOe) != 8'h00);
endmodule : p6g_port
`default_nettype wire

// ===== testbench/p6g_pin_model.sv
// Outside world of the port: resolves each pad from port drive, outside drive and pull-up
`default_nettype none
module p6g_pin_model (
    // Clock
    input wire logic sys_clk,
    // Port side of the pads
    input wire p6g_pkg::p6g_byte_t padOut,
    input wire p6g_pkg::p6g_byte_t padOe,
    input wire p6g_pkg::p6g_byte_t padPullUp,
    // Outside drivers, one enable per pin
    input wire p6g_pkg::p6g_byte_t extLevel,
    input wire p6g_pkg::p6g_byte_t extEn,
    // Resolved pad levels back into the port
    output p6g_pkg::p6g_byte_t padIn
);
    timeunit 1ns;
    timeprecision 1ns;
    import p6g_pkg::*;
    // ==========================================================
    // Floating pins
    // A pin nobody drives flips every cycle, so a stale level never passes for a drive
    p6g_byte_t floatPat_q = 8'h00;
    always_ff @(posedge sys_clk)
    begin
        floatPat_q <= ~floatPat_q;
    end
    // ==========================================================
    // Pad resolution: port drive first, then outside drive, then pull-up
    assign padIn = (padOe & padOut) | (~padOe & extEn & extLevel)
        | (~padOe & ~extEn & padPullUp)
        | (~padOe & ~extEn & ~padPullUp & floatPat_q);
endmodule : p6g_pin_model
`default_nettype wire

// ===== testbench/test_p6g_port.sv
// Self-checking bench of the eight-bit shared-pin port
`default_nettype none
module test_p6g_port;
    timeunit 1ns;
    timeprecision 1ns;
    import p6g_pkg::*;
    // ==========================================================
    // Signals
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    p6g_addr_t regAddr = 8'h00;
    p6g_byte_t regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic regRdRmw = 1'b0;
    p6g_byte_t regRdData;
    logic stopWatchMode = 1'b0;
    // Shared function drive, indexed by pin
    p6g_byte_t periOut = 8'h00;
    p6g_byte_t periOe = 8'h00;
    logic compTimerExtClock;
    logic serialClockIn;
    logic serialDataIn;
    p6g_byte_t padIn;
    p6g_byte_t padOut;
    p6g_byte_t padOe;
    p6g_byte_t padPullUp;
    // Outside drivers of the pads
    p6g_byte_t extLevel = 8'h00;
    p6g_byte_t extEn = 8'hFF; // Pins start held low from outside, so reset reads are defined
    // Read result and score
    p6g_byte_t v;
    int failures = 0;
    int checked = 0;
    // ==========================================================
    // Clock, 100 ns period
    always #50 sys_clk = ~sys_clk;
    // ==========================================================
    // Instances
    p6g_port p6g_port_i (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdRmw(regRdRmw),
        .regRdData(regRdData), .stopWatchMode(stopWatchMode),
        .pulseGenOutA(periOut[PIN_PG_A]), .pulseGenOutAOe(periOe[PIN_PG_A]),
        .pulseGenOutB(periOut[PIN_PG_B]), .pulseGenOutBOe(periOe[PIN_PG_B]),
        .compTimerOutA(periOut[PIN_CT_A]), .compTimerOutAOe(periOe[PIN_CT_A]),
        .compTimerOutB(periOut[PIN_CT_B]), .compTimerOutBOe(periOe[PIN_CT_B]),
        .serialClockOut(periOut[PIN_SER_CLK]), .serialClockOutOe(periOe[PIN_SER_CLK]),
        .serialDataOut(periOut[PIN_SER_OUT]), .serialDataOutOe(periOe[PIN_SER_OUT]),
        .compTimerExtClock(compTimerExtClock), .serialClockIn(serialClockIn),
        .serialDataIn(serialDataIn), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .padPullUp(padPullUp));
    p6g_pin_model p6g_pin_model_i (.sys_clk(sys_clk), .padOut(padOut), .padOe(padOe),
        .padPullUp(padPullUp), .extLevel(extLevel), .extEn(extEn), .padIn(padIn));
    // ==========================================================
    // Shared tasks
    // Compare and count; case inequality so an unknown never matches
    task automatic check(input string what, input p6g_byte_t exp, input p6g_byte_t got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One-cycle write; a gap cycle follows so the strobe is never set twice in one step
    task automatic wr(input p6g_addr_t a, input p6g_byte_t d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
        @(posedge sys_clk);
        // Ends just past the edge so a pad launched there is seen settled
        #1;
    endtask : wr
    // One-cycle read; data are taken inside the following cycle only
    task automatic rd(input p6g_addr_t a, input logic rmw, output p6g_byte_t d);
        regAddr <= a;
        regRdRmw <= rmw;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
        @(posedge sys_clk);
    endtask : rd
    // ==========================================================
    // Scenarios
    // Registers come out of reset cleared, all pins input; unmapped address reads zero
    task automatic test_reset;
        for (int a = 0; a < 6; a++)
        begin
            rd(a[7:0], 1'b0, v);
            check("reset read", 8'h00, v);
        end
        check("reset padOe", 8'h00, padOe);
        $display("test reset done");
    endtask : test_reset
    // Outputs drive the latch level, bit n on pin n
    task automatic test_output;
        wr(OFF_DIR, 8'hFF);
        wr(OFF_LATCH, 8'hA5);
        check("out padOe", 8'hFF, padOe);
        check("out padOut", 8'hA5, padOut);
        rd(OFF_LATCH, 1'b0, v);
        check("out read", 8'hA5, v);
        wr(OFF_DIR, 8'h01);
        check("one pin padOe", 8'h01, padOe);
        $display("test output done");
    endtask : test_output
    // Inputs read the pin, read-modify-write reads the latch, latch kept for later
    task automatic test_input;
        extLevel <= 8'h5A;
        extEn <= 8'hFF;
        wr(OFF_DIR, 8'h00);
        wr(OFF_LATCH, 8'h3C);
        repeat (3) @(posedge sys_clk);
        check("in padOe", 8'h00, padOe);
        rd(OFF_LATCH, 1'b0, v);
        check("in read", 8'h5A, v);
        rd(OFF_LATCH, 1'b1, v);
        check("in rmw read", 8'h3C, v);
        wr(OFF_DIR, 8'h0F);
        rd(OFF_LATCH, 1'b0, v);
        check("mixed read", 8'h5C, v);
        extEn <= 8'h00;
        wr(OFF_DIR, 8'hFF);
        check("stored latch", 8'h3C, padOut);
        $display("test input done");
    endtask : test_input
    // Peripherals take their pins; reads see the pins, inputs reach the peripherals
    task automatic test_periph;
        wr(OFF_DIR, 8'h00);
        wr(OFF_LATCH, 8'h4A);
        extLevel <= 8'h90;
        extEn <= 8'h90;
        periOut <= 8'h25;
        periOe <= 8'h6F;
        repeat (5) @(posedge sys_clk);
        check("peri padOe", 8'h6F, padOe);
        check("peri padOut", 8'h25, padOut & 8'h6F);
        rd(OFF_LATCH, 1'b0, v);
        check("peri read", 8'hB5, v);
        rd(OFF_LATCH, 1'b1, v);
        check("peri rmw read", 8'h4A, v);
        check("peri inputs", 8'h07, {5'h00, serialDataIn, serialClockIn, compTimerExtClock});
        periOe <= 8'h00;
        extEn <= 8'h00;
        repeat (3) @(posedge sys_clk);
        check("peri released", 8'h00, padOe);
        $display("test periph done");
    endtask : test_periph
    // Pull-up connects where configured, but never on a pin driven low
    task automatic test_pullup;
        wr(OFF_DIR, 8'hFF);
        wr(OFF_LATCH, 8'h0F);
        wr(OFF_PULLUP, 8'hFF);
        check("low drops pull", 8'h0F, padPullUp);
        wr(OFF_DIR, 8'h00);
        check("pull on", 8'hFF, padPullUp);
        repeat (2) @(posedge sys_clk);
        rd(OFF_LATCH, 1'b0, v);
        check("pulled read", 8'hFF, v);
        wr(OFF_PULLUP, 8'h00);
        $display("test pullup done");
    endtask : test_pullup
    // Standby: floating option gates inputs except enabled irq pins; hold option freezes
    task automatic test_standby;
        wr(OFF_LATCH, 8'h55);
        wr(OFF_DIR, 8'hFF);
        wr(OFF_STBY, 8'h1F);
        extLevel <= 8'hFF;
        extEn <= 8'hFF;
        stopWatchMode <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check("stby padOe", 8'h00, padOe);
        rd(OFF_PINS, 1'b0, v);
        check("irq pins open", 8'hA0, v);
        stopWatchMode <= 1'b0;
        wr(OFF_STBY, 8'h13); // one enable per pin is not enough
        stopWatchMode <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(OFF_PINS, 1'b0, v);
        check("gated pins", 8'h00, v);
        stopWatchMode <= 1'b0;
        extEn <= 8'h00;
        wr(OFF_STBY, 8'h00);
        stopWatchMode <= 1'b1;
        repeat (2) @(posedge sys_clk);
        wr(OFF_LATCH, 8'hAA);
        repeat (2) @(posedge sys_clk);
        check("held padOut", 8'h55, padOut);
        check("held padOe", 8'hFF, padOe);
        stopWatchMode <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("after hold", 8'hAA, padOut);
        $display("test standby done");
    endtask : test_standby
    // ==========================================================
    // Verdict, the only place the run ends
    task automatic stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    // Main sequence: reset held for three cycles, then each scenario in turn
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        test_reset();
        test_output();
        test_input();
        test_periph();
        test_pullup();
        test_standby();
        stop_test();
    end
    // Watchdog: the scenarios need about a hundred cycles, so 3000 means a hang
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        failures++;
        stop_test();
    end
endmodule : test_p6g_port
`default_nettype wire
